/* core/bcpr_pkg.sv */
// Purpose: Shared constants for bundle capture and poison reporting
// Assumes: APB slave, 32-bit data, word aligned registers
// Notes: Offsets are byte addresses
package bcpr_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [7:0] OFF_FEAT = 8'h00;
  localparam logic [7:0] OFF_FSET = 8'h04;
  localparam logic [7:0] OFF_CAPLO0 = 8'h08;
  localparam logic [7:0] OFF_CAPLO1 = 8'h0c;
  localparam logic [7:0] OFF_CAPHI0 = 8'h10;
  localparam logic [7:0] OFF_CAPHI1 = 8'h14;
  localparam logic [7:0] OFF_STATE = 8'h18;
  localparam logic [7:0] OFF_CCHK = 8'h1c;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h20;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h24;
  localparam logic [7:0] OFF_VTRAP = 8'h28;
  // ==========================================================
  // Feature register, upper word of the 64-bit feature vector
  localparam int FEAT_CAPTURE_BIT = 35 - 32;
  localparam int FEAT_PROMOTE_BIT = 53 - 32;
  localparam int FEAT_CEI_PROMO_BIT = 60 - 32;
  // ==========================================================
  // Processor state parameter bit positions within OFF_STATE, check bits within OFF_CCHK
  localparam int STP_CORRECTED = 0;
  localparam int STP_UNRECOV = 1;
  localparam int STP_STATE_CONT = 2;
  localparam int STP_CONT = 3;
  localparam int STP_SYNC = 4;
  localparam logic [4:0] STP_ABORT_PAT = 5'h0c;
  localparam logic [4:0] STP_CORR_PAT = 5'h01;
  localparam int CCHK_POISON_BIT = 23;
  localparam int BCHK_POISON_BIT = 24;
  localparam int CCHK_OTHER_BIT = 25;
  localparam int CCHK_CONT_BIT = 26;
  // ==========================================================
  // Interrupt status bits
  localparam int IRQ_CORR = 0;
  localparam int IRQ_ABORT = 1;
  localparam int IRQ_VTRAP = 2;
  localparam int IRQ_W = 3;
  // Interruption control register numbers
  localparam logic [6:0] CR_CAP_LO = 7'h1a;
  localparam logic [6:0] CR_CAP_HI = 7'h1b;
endpackage : bcpr_pkg

/* core/bcpr_cap_mem.sv */
// Purpose: Holds the 16-byte bundle capture pair
// Assumes: One write port, registered read
// Notes: Two 64-bit words, low and high half
module bcpr_cap_mem #(
  parameter int WIDTH = 64
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Write port
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_lo,
  input wire logic [WIDTH-1:0] wr_hi,
  // Read port
  input wire logic [1:0] rd_sel,
  output logic [31:0] rd_data
);
  typedef struct packed {
    logic [WIDTH-1:0] lo;
    logic [WIDTH-1:0] hi;
    logic [31:0] rd;
  } bcpr_mem_t;
  bcpr_mem_t st_ff, nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (wr_en) begin
      nxt_st.lo = wr_lo;
      nxt_st.hi = wr_hi;
    end
    case (rd_sel)
      2'h0: nxt_st.rd = st_ff.lo[31:0];
      2'h1: nxt_st.rd = st_ff.lo[63:32];
      2'h2: nxt_st.rd = st_ff.hi[31:0];
      default: nxt_st.rd = st_ff.hi[63:32];
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rd_data = st_ff.rd;
endmodule : bcpr_cap_mem

/* core/bcpr_poison.sv */
// Purpose: Chooses signalling and state flags for unconsumed poison
// Assumes: Event is a one-cycle pulse
// Notes: Outputs registered one cycle after the event
module bcpr_poison (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Event
  input wire logic poison_evt,
  input wire logic consumer,
  input wire logic promote,
  // Result
  output logic corrected_error_interrupt,
  output logic machine_check_abort,
  output logic [4:0] state_param
);
  typedef struct packed {
    logic cei;
    logic abort;
    logic [4:0] state_param;
  } bcpr_poi_t;
  bcpr_poi_t st_ff, nxt_st;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.cei = 1'b0;
    nxt_st.abort = 1'b0;
    // Consumed poison is reported elsewhere
    if (poison_evt && !consumer) begin // [RULE6]
      if (promote) begin // [RULE8]
        nxt_st.abort = 1'b1;
        nxt_st.state_param = bcpr_pkg::STP_ABORT_PAT; // [RULE12]
      end else begin
        nxt_st.cei = 1'b1; // [RULE7]
        nxt_st.state_param = bcpr_pkg::STP_CORR_PAT; // [RULE11]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign corrected_error_interrupt = st_ff.cei;
  assign machine_check_abort = st_ff.abort;
  assign state_param = st_ff.state_param;

  chk_abort_flags: assert property (@(posedge pclk) disable iff (!presetn) // [RULE12]
    poison_evt && !consumer && promote |=> machine_check_abort && state_param == 5'h0c)
    else $error("abort flags wrong");
  chk_corr_flag: assert property (@(posedge pclk) disable iff (!presetn) // [RULE11]
    poison_evt && !consumer && !promote |=> corrected_error_interrupt && state_param[0])
    else $error("corrected flag wrong");
endmodule : bcpr_poison

/* core/bcpr_top.sv */
// Purpose: Bundle capture registers and poison reporting over APB
// Assumes: Synchronous inputs, one clock pclk
// Notes: Read of status clears it
// Summary of operation
// RULE1: Capture full 16-byte bundle on interruption
// RULE2: No capture leaves registers undefined
// RULE3: Feature bit 35 reports capture present
// RULE4: Bit 35 read-only, set value ignored
// RULE5: Trap CRs 16,17,19-27 as one class
// RULE6: Poison unconsumed when receiver not consumer
// RULE7: Default corrected check, bit 53 promotes
// RULE8: Bit 53 selects interrupt or abort
// RULE9: Bit 60 does not affect poison
// RULE10: Unsupported promotion ignores bit 53 write
// RULE11: Corrected signalling sets corrected flag
// RULE12: Abort flags: 0,0,1,1,0
// RULE13: Continuable when promoted, pattern, no other
// RULE14: Poison indicator bit 23 when unconsumed
module bcpr_top #(
  parameter bit CAPTURE_IMPL = 1'b1,
  parameter bit PROMOTE_IMPL = 1'b1
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interruption capture
  input wire logic intr_valid,
  input wire logic intr_capture,
  input wire logic [63:0] bundle_lo,
  input wire logic [63:0] bundle_hi,
  // Control register moves from guest
  input wire logic cr_move,
  input wire logic [6:0] cr_num,
  input wire logic virt_mode,
  output logic cr_trap,
  // Poison events
  input wire logic poison_evt,
  input wire logic poison_consumer,
  input wire logic poison_cache,
  input wire logic other_error,
  // Results
  output logic corrected_error_interrupt,
  output logic machine_check_abort,
  output logic irq
);
  // ==========================================================
  // State
  typedef struct packed {
    logic [31:0] feat;
    logic [31:0] cchk;
    logic [bcpr_pkg::IRQ_W-1:0] stat;
    logic [bcpr_pkg::IRQ_W-1:0] mask;
    logic [6:0] vtrap_cr;
    logic trap;
    logic [31:0] rdata;
    logic rsel_mem;
    logic ack;
  } bcpr_top_t;
  bcpr_top_t st_ff, nxt_st;

  logic [4:0] state_param;
  logic [31:0] mem_rd;
  logic [1:0] mem_sel;
  logic access;
  logic promote;

  function automatic logic is_intr_cr(input logic [6:0] n);
    is_intr_cr = (n == 7'h10) || (n == 7'h11) || (n >= 7'h13 && n <= bcpr_pkg::CR_CAP_HI);
  endfunction : is_intr_cr

  assign access = psel && penable;
  assign promote = st_ff.feat[bcpr_pkg::FEAT_PROMOTE_BIT];

  // ==========================================================
  // Capture storage
  bcpr_cap_mem #(.WIDTH(64)) u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(intr_valid && intr_capture && CAPTURE_IMPL), // [RULE1] [RULE2]
    .wr_lo(bundle_lo),
    .wr_hi(bundle_hi),
    .rd_sel(mem_sel),
    .rd_data(mem_rd)
  );

  always_comb begin
    case (paddr)
      bcpr_pkg::OFF_CAPLO1: mem_sel = 2'h1;
      bcpr_pkg::OFF_CAPHI0: mem_sel = 2'h2;
      bcpr_pkg::OFF_CAPHI1: mem_sel = 2'h3;
      default: mem_sel = 2'h0;
    endcase
  end

  // ==========================================================
  // Poison signalling
  bcpr_poison u_poi (
    .pclk(pclk),
    .presetn(presetn),
    .poison_evt(poison_evt),
    .consumer(poison_consumer),
    .promote(promote), // [RULE9]
    .corrected_error_interrupt(corrected_error_interrupt),
    .machine_check_abort(machine_check_abort),
    .state_param(state_param)
  );

  // ==========================================================
  // Next state
  always_comb begin
    nxt_st = st_ff;
    nxt_st.ack = 1'b0;
    nxt_st.rsel_mem = 1'b0;
    nxt_st.trap = 1'b0;
    nxt_st.feat[bcpr_pkg::FEAT_CAPTURE_BIT] = CAPTURE_IMPL; // [RULE3]
    if (cr_move && virt_mode && is_intr_cr(cr_num)) begin // [RULE5]
      nxt_st.trap = 1'b1;
      nxt_st.vtrap_cr = cr_num;
      nxt_st.stat[bcpr_pkg::IRQ_VTRAP] = 1'b1;
    end
    if (poison_evt && !poison_consumer) begin
      nxt_st.cchk[bcpr_pkg::CCHK_POISON_BIT] = poison_cache; // [RULE14]
      nxt_st.cchk[bcpr_pkg::BCHK_POISON_BIT] = !poison_cache;
      nxt_st.cchk[bcpr_pkg::CCHK_OTHER_BIT] = other_error;
      nxt_st.cchk[bcpr_pkg::CCHK_CONT_BIT] = promote && !other_error; // [RULE13]
    end
    if (psel && !penable) begin
      nxt_st.ack = 1'b1;
      nxt_st.rsel_mem = (paddr >= bcpr_pkg::OFF_CAPLO0) && (paddr <= bcpr_pkg::OFF_CAPHI1);
      case (paddr)
        bcpr_pkg::OFF_FEAT: nxt_st.rdata = st_ff.feat;
        bcpr_pkg::OFF_STATE: nxt_st.rdata = {27'h0, state_param};
        bcpr_pkg::OFF_CCHK: nxt_st.rdata = st_ff.cchk;
        bcpr_pkg::OFF_IRQ_STAT: nxt_st.rdata = {29'h0, st_ff.stat};
        bcpr_pkg::OFF_IRQ_MASK: nxt_st.rdata = {29'h0, st_ff.mask};
        bcpr_pkg::OFF_VTRAP: nxt_st.rdata = {25'h0, st_ff.vtrap_cr};
        default: nxt_st.rdata = 32'h0;
      endcase
    end
    if (access && st_ff.ack) begin
      if (pwrite) begin
        if (paddr == bcpr_pkg::OFF_FSET) begin
          // Capture bit kept as read-only, promote only if supported
          if (PROMOTE_IMPL) begin // [RULE10]
            nxt_st.feat[bcpr_pkg::FEAT_PROMOTE_BIT] = pwdata[bcpr_pkg::FEAT_PROMOTE_BIT];
          end
          nxt_st.feat[bcpr_pkg::FEAT_CEI_PROMO_BIT] = pwdata[bcpr_pkg::FEAT_CEI_PROMO_BIT];
        end // [RULE4]
        if (paddr == bcpr_pkg::OFF_IRQ_MASK) begin
          nxt_st.mask = pwdata[bcpr_pkg::IRQ_W-1:0];
        end
      end else if (paddr == bcpr_pkg::OFF_IRQ_STAT) begin
        nxt_st.stat = '0;
      end
    end
    // Events set after the clear so a coincident event survives
    if (corrected_error_interrupt) begin
      nxt_st.stat[bcpr_pkg::IRQ_CORR] = 1'b1;
    end
    if (machine_check_abort) begin
      nxt_st.stat[bcpr_pkg::IRQ_ABORT] = 1'b1;
    end
    if (st_ff.trap) begin
      nxt_st.stat[bcpr_pkg::IRQ_VTRAP] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pready = st_ff.ack;
  assign pslverr = 1'b0;
  assign prdata = st_ff.rsel_mem ? mem_rd : st_ff.rdata;
  assign cr_trap = st_ff.trap;
  assign irq = |(st_ff.stat & st_ff.mask);

  // Skips the first edge after reset, while the bit is still loading
  chk_feat_ro: assert property (@(posedge pclk) disable iff (!presetn) // [RULE4]
    $past(presetn) |-> st_ff.feat[bcpr_pkg::FEAT_CAPTURE_BIT] == CAPTURE_IMPL)
    else $error("capture feature bit changed");
  chk_promote_unsup: assert property (@(posedge pclk) disable iff (!presetn) // [RULE10]
    !PROMOTE_IMPL |-> !st_ff.feat[bcpr_pkg::FEAT_PROMOTE_BIT])
    else $error("unsupported promote bit set");
  chk_cr_trap: assert property (@(posedge pclk) disable iff (!presetn)
    cr_move && virt_mode && cr_num == bcpr_pkg::CR_CAP_HI |=> cr_trap)
    else $error("capture register move not trapped"); // [RULE5]
  chk_cr_notrap: assert property (@(posedge pclk) disable iff (!presetn)
    cr_move && virt_mode && cr_num == 7'h12 |=> !cr_trap)
    else $error("cr18 trapped"); // [RULE5]
  chk_poison_bit: assert property (@(posedge pclk) disable iff (!presetn)
    poison_evt && !poison_consumer && poison_cache |=> st_ff.cchk[23])
    else $error("poison indicator not set"); // [RULE14]
  chk_cont_flag: assert property (@(posedge pclk) disable iff (!presetn)
    poison_evt && !poison_consumer && promote && !other_error |=> st_ff.cchk[26])
    else $error("continuable not reported"); // [RULE13]
  chk_ready_timing: assert property (@(posedge pclk) disable iff (!presetn)
    psel && !penable |=> pready)
    else $error("pready late");
endmodule : bcpr_top

/* tb/bcpr_top_tb.sv */
// Purpose: Self-checking bench for bundle capture and poison reporting
// Assumes: One-cycle APB access phase, registered event outputs
// Notes: Inputs change by NBA on the rising edge
module bcpr_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin bad_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
  logic pclk = 1'b0, presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, cr_trap, cei, mc_abort, irq;
  logic [31:0] prdata_min, rd_min;
  logic intr_valid = 1'b0, intr_capture = 1'b0;
  logic [63:0] bundle_lo = 64'h0, bundle_hi = 64'h0;
  logic cr_move = 1'b0, virt_mode = 1'b0;
  logic [6:0] cr_num = 7'h00;
  logic poison_evt = 1'b0, poison_consumer = 1'b0, poison_cache = 1'b0;
  logic other_error = 1'b0;
  int bad_count = 0, checks = 0;
  always #2 pclk = ~pclk;
  bcpr_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .intr_valid(intr_valid),
    .intr_capture(intr_capture), .bundle_lo(bundle_lo), .bundle_hi(bundle_hi),
    .cr_move(cr_move), .cr_num(cr_num), .virt_mode(virt_mode), .cr_trap(cr_trap),
    .poison_evt(poison_evt), .poison_consumer(poison_consumer),
    .poison_cache(poison_cache), .other_error(other_error),
    .corrected_error_interrupt(cei), .machine_check_abort(mc_abort), .irq(irq));
  // Variant with neither option built in, sharing the same stimulus
  bcpr_top #(.CAPTURE_IMPL(1'b0), .PROMOTE_IMPL(1'b0)) dut_min (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata_min), .pready(), .pslverr(),
    .intr_valid(intr_valid), .intr_capture(intr_capture), .bundle_lo(bundle_lo),
    .bundle_hi(bundle_hi), .cr_move(cr_move), .cr_num(cr_num), .virt_mode(virt_mode),
    .cr_trap(), .poison_evt(poison_evt), .poison_consumer(poison_consumer),
    .poison_cache(poison_cache), .other_error(other_error),
    .corrected_error_interrupt(), .machine_check_abort(), .irq());
  // ==========================================================
  // APB master: hold request until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 50) begin
      bad_count++;
    end
    // Taken at the edge where pready is seen, before the design updates
    rd = prdata;
    rd_min = prdata_min;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // ==========================================================
  // One poison pulse; outputs checked in the cycle after it
  task automatic poison(input logic cons, cache, oth, input logic exp_c, exp_m);
    @(posedge pclk);
    poison_evt <= 1'b1;
    poison_consumer <= cons;
    poison_cache <= cache;
    other_error <= oth;
    @(posedge pclk);
    poison_evt <= 1'b0;
    #1;
    `CHK(cei, exp_c)
    `CHK(mc_abort, exp_m)
  endtask : poison
  task automatic end_of_test;
    if (bad_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_of_test
  initial begin
    #40000;
    bad_count++;
    end_of_test();
  end
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    // Feature bits after reset and after a try to clear bit 35
    apb(1'b0, bcpr_pkg::OFF_FEAT, 32'h0);
    `CHK(rd[bcpr_pkg::FEAT_CAPTURE_BIT], 1'b1)
    `CHK(rd[bcpr_pkg::FEAT_PROMOTE_BIT], 1'b0)
    `CHK(rd_min[bcpr_pkg::FEAT_CAPTURE_BIT], 1'b0)
    apb(1'b1, bcpr_pkg::OFF_FSET, 32'h1000_0000);
    apb(1'b0, bcpr_pkg::OFF_FEAT, 32'h0);
    `CHK(rd[bcpr_pkg::FEAT_CAPTURE_BIT], 1'b1)
    // Corrected path, bit 60 set must not matter
    apb(1'b0, bcpr_pkg::OFF_IRQ_STAT, 32'h0);
    apb(1'b1, bcpr_pkg::OFF_IRQ_MASK, 32'h2);
    poison(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
    apb(1'b0, bcpr_pkg::OFF_STATE, 32'h0);
    `CHK(rd[4:0], 5'h01)
    // Status bit now set but masked off
    `CHK(irq, 1'b0)
    apb(1'b0, bcpr_pkg::OFF_CCHK, 32'h0);
    `CHK(rd[bcpr_pkg::CCHK_POISON_BIT], 1'b1)
    apb(1'b0, bcpr_pkg::OFF_IRQ_STAT, 32'h0);
    `CHK(rd[2:0], 3'h1)
    // Consumer sees no unconsumed event
    poison(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    // Unmasked interrupt raised then cleared by status read
    apb(1'b1, bcpr_pkg::OFF_IRQ_MASK, 32'h1);
    poison(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    #4;
    `CHK(irq, 1'b1)
    apb(1'b0, bcpr_pkg::OFF_IRQ_STAT, 32'h0);
    #1;
    `CHK(irq, 1'b0)
    // Promotion to abort
    apb(1'b1, bcpr_pkg::OFF_FSET, 32'h0020_0000);
    apb(1'b0, bcpr_pkg::OFF_FEAT, 32'h0);
    `CHK(rd[bcpr_pkg::FEAT_PROMOTE_BIT], 1'b1)
    `CHK(rd_min[bcpr_pkg::FEAT_PROMOTE_BIT], 1'b0)
    poison(1'b0, 1'b1, 1'b0, 1'b0, 1'b1);
    apb(1'b0, bcpr_pkg::OFF_STATE, 32'h0);
    `CHK(rd[4:0], 5'h0c)
    apb(1'b0, bcpr_pkg::OFF_CCHK, 32'h0);
    `CHK(rd[bcpr_pkg::CCHK_CONT_BIT], 1'b1)
    apb(1'b0, bcpr_pkg::OFF_IRQ_STAT, 32'h0);
    `CHK(rd[2:0], 3'h2)
    // Bundle capture read back as four words
    @(posedge pclk);
    intr_valid <= 1'b1;
    intr_capture <= 1'b1;
    bundle_lo <= 64'h0123_4567_89ab_cdef;
    bundle_hi <= 64'hfedc_ba98_7654_3210;
    @(posedge pclk);
    intr_valid <= 1'b0;
    apb(1'b0, bcpr_pkg::OFF_CAPLO0, 32'h0);
    `CHK(rd, 32'h89ab_cdef)
    apb(1'b0, bcpr_pkg::OFF_CAPLO1, 32'h0);
    `CHK(rd, 32'h0123_4567)
    apb(1'b0, bcpr_pkg::OFF_CAPHI0, 32'h0);
    `CHK(rd, 32'h7654_3210)
    apb(1'b0, bcpr_pkg::OFF_CAPHI1, 32'h0);
    `CHK(rd, 32'hfedc_ba98)
    // Control register moves 14 to 29, virtual for all but 29, only the class trapped
    for (int i = 14; i <= 29; i++) begin
      @(posedge pclk);
      cr_move <= 1'b1;
      cr_num <= 7'(i);
      virt_mode <= (i != 29);
      @(posedge pclk);
      cr_move <= 1'b0;
      #1;
      `CHK(cr_trap, 1'(i == 16 || i == 17 || (i >= 19 && i <= 27)))
    end
    apb(1'b0, bcpr_pkg::OFF_VTRAP, 32'h0);
    `CHK(rd[6:0], 7'h1b)
    apb(1'b0, bcpr_pkg::OFF_IRQ_STAT, 32'h0);
    `CHK(rd[2:0], 3'h4)
    // Unmapped place reads zero
    apb(1'b1, 8'h3c, 32'hffff_ffff);
    apb(1'b0, 8'h3c, 32'h0);
    `CHK(rd, 32'h0000_0000)
    end_of_test();
  end
endmodule : bcpr_top_tb
